/* inc/gts_pkg.sv */
package gts_pkg;
  // ****************************************
  // Register map (word offsets as byte addresses)
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CON1 = 6'h00;
  localparam logic [5:0] OFS_CNT1 = 6'h04;
  localparam logic [5:0] OFS_PER1 = 6'h08;
  localparam logic [5:0] OFS_CON2 = 6'h0c;
  localparam logic [5:0] OFS_CNT2 = 6'h10;
  localparam logic [5:0] OFS_PER2 = 6'h14;
  localparam logic [5:0] OFS_CON3 = 6'h18;
  localparam logic [5:0] OFS_CNT3 = 6'h1c;
  localparam logic [5:0] OFS_PER3 = 6'h20;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h24;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
  localparam logic [5:0] OFS_MISC = 6'h2c;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int B_TIMER_ON = 15;
  localparam int B_STOP_IDLE = 13;
  localparam int B_GATE_EN = 6;
  localparam int B_PRESC_HI = 5;
  localparam int B_PRESC_LO = 4;
  localparam int B_PAIR_JOIN = 3;
  localparam int B_EXT_SYNC = 2;
  localparam int B_CLK_SRC = 1;
  localparam logic [15:0] CON1_MASK = 16'ha076;
  localparam logic [15:0] CON2_MASK = 16'ha07a;
  localparam logic [15:0] CON3_MASK = 16'ha072;
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;
  // Interrupt status bits
  localparam int IRQ_PRIM = 0;
  localparam int IRQ_LOW = 1;
  localparam int IRQ_UP = 2;
  localparam int IRQ_W = 3;
  // Prescale terminal counts
  localparam logic [7:0] PS_DIV1 = 8'h00;
  localparam logic [7:0] PS_DIV8 = 8'h07;
  localparam logic [7:0] PS_DIV64 = 8'h3f;
  localparam logic [7:0] PS_DIV256 = 8'hff;

  typedef struct packed {
    logic timer_on;
    logic stop_in_idle;
    logic gate_accumulate_en;
    logic [1:0] prescale_sel;
    logic pair_join;
    logic ext_clock_sync;
    logic clock_source_sel;
  } gts_ctl_t;

  typedef struct packed {
    logic primary_ext_clock_pin;
    logic lower_ext_clock_pin;
    logic upper_ext_clock_pin;
    logic primary_gate;
    logic lower_gate;
    logic upper_gate;
  } gts_pins_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } gts_bus_st_t;

  function automatic gts_ctl_t gts_unpack(input logic [15:0] r);
    gts_ctl_t c;
    c.timer_on = r[B_TIMER_ON];
    c.stop_in_idle = r[B_STOP_IDLE];
    c.gate_accumulate_en = r[B_GATE_EN];
    c.prescale_sel = r[B_PRESC_HI:B_PRESC_LO];
    c.pair_join = r[B_PAIR_JOIN];
    c.ext_clock_sync = r[B_EXT_SYNC];
    c.clock_source_sel = r[B_CLK_SRC];
    return c;
  endfunction

  function automatic logic [7:0] gts_ps_term(input logic [1:0] sel);
    case (sel)
      2'b00: return PS_DIV1;
      2'b01: return PS_DIV8;
      2'b10: return PS_DIV64;
      default: return PS_DIV256;
    endcase
  endfunction
endpackage

/* verilog/gts_timer_set.sv */
`timescale 1ns/1ps
module gts_timer_set (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [gts_pkg::ADDR_W-1:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Wait request
  input wire gts_pkg::gts_pins_t pins_i, // Clock and gate pins
  input wire logic cpu_idle_i, // Device in idle mode
  output logic irq_o, // Level interrupt
  output logic [15:0] lower_timebase_o, // Lower pair count
  output logic [15:0] upper_timebase_o, // Upper pair count
  output logic converter_trig_o // Joined pair match pulse
);
  import gts_pkg::*;

  // ****************************************
  // Reset and pin synchronisers
  // ****************************************
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  gts_pins_t pin_s1_r, pin_s2_r, pin_s3_r;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= pins_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] con1_r, con2_r, con3_r;
  logic [15:0] per1_r, per2_r, per3_r;
  logic [15:0] cnt1_r, cnt2_r, cnt3_r;
  logic [IRQ_W-1:0] stat_r, mask_r;
  gts_bus_st_t bus_st_r;
  logic [31:0] rdata_r;
  gts_ctl_t c1, c2, c3;
  assign c1 = gts_unpack(con1_r);
  assign c2 = gts_unpack(con2_r);
  assign c3 = gts_unpack(con3_r);

  logic wr, joined;
  logic [15:0] wd;
  logic [15:0] lane_m;
  // Writes land only at the edge where waitrequest is sampled low
  assign wr = avs_write_i && (bus_st_r == BUS_RESP);
  assign lane_m = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wd = avs_writedata_i[15:0];
  assign joined = c2.pair_join;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m, input logic [15:0] fm);
    return ((old & ~m) | (nw & m)) & fm;
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      con1_r <= CON_RST;
      con2_r <= CON_RST;
      con3_r <= CON_RST;
      per1_r <= PER_RST;
      per2_r <= PER_RST;
      per3_r <= PER_RST;
      mask_r <= '0;
    end else if (wr) begin
      case (avs_address_i)
        OFS_CON1: con1_r <= merge(con1_r, wd, lane_m, CON1_MASK);
        OFS_CON2: con2_r <= merge(con2_r, wd, lane_m, CON2_MASK);
        OFS_CON3: con3_r <= merge(con3_r, wd, lane_m, CON3_MASK);
        OFS_PER1: per1_r <= merge(per1_r, wd, lane_m, 16'hffff);
        OFS_PER2: per2_r <= merge(per2_r, wd, lane_m, 16'hffff);
        OFS_PER3: per3_r <= merge(per3_r, wd, lane_m, 16'hffff);
        OFS_IRQ_MASK: if (avs_byteenable_i[0]) mask_r <= wd[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Primary timer tick generation
  // ****************************************
  // Async mode: raw pin edge seen after only the metastability stage pair;
  // sync mode adds a further stage so the edge aligns to the core clock.
  logic p1_edge_async, p1_edge_sync, p1_ext_edge, p1_gate, p1_gate_fall;
  assign p1_edge_async = pin_s2_r.primary_ext_clock_pin & ~pin_s3_r.primary_ext_clock_pin;
  logic p1_sync_d_r;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) p1_sync_d_r <= 1'b0;
    else p1_sync_d_r <= p1_edge_async;
  end
  assign p1_edge_sync = p1_sync_d_r;
  assign p1_ext_edge = c1.ext_clock_sync ? p1_edge_sync : p1_edge_async;
  assign p1_gate = pin_s2_r.primary_gate;
  assign p1_gate_fall = ~pin_s2_r.primary_gate & pin_s3_r.primary_gate;

  // Per-timer run and raw tick
  logic run1, run2, run3, raw1, raw2, raw3;
  assign run1 = c1.timer_on && !(c1.stop_in_idle && cpu_idle_i);
  assign run2 = c2.timer_on && !(c2.stop_in_idle && cpu_idle_i);
  assign run3 = c3.timer_on && !(c3.stop_in_idle && cpu_idle_i) && !joined;
  assign raw1 = c1.clock_source_sel ? p1_ext_edge : (!c1.gate_accumulate_en || p1_gate);
  // Pair timers only have the async-mode external path, with no extra sync stage
  assign raw2 = c2.clock_source_sel ?
                (pin_s2_r.lower_ext_clock_pin & ~pin_s3_r.lower_ext_clock_pin) :
                (!c2.gate_accumulate_en || pin_s2_r.lower_gate);
  assign raw3 = c3.clock_source_sel ?
                (pin_s2_r.upper_ext_clock_pin & ~pin_s3_r.upper_ext_clock_pin) :
                (!c3.gate_accumulate_en || pin_s2_r.upper_gate);

  // ****************************************
  // Prescalers
  // ****************************************
  logic [7:0] ps1_r, ps2_r, ps3_r;
  logic tick1, tick2, tick3;
  assign tick1 = run1 && raw1 && (ps1_r == gts_ps_term(c1.prescale_sel));
  assign tick2 = run2 && raw2 && (ps2_r == gts_ps_term(c2.prescale_sel));
  assign tick3 = run3 && raw3 && (ps3_r == gts_ps_term(c3.prescale_sel));

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ps1_r <= '0;
      ps2_r <= '0;
      ps3_r <= '0;
    end else begin
      if (!run1) ps1_r <= '0;
      else if (raw1) ps1_r <= tick1 ? 8'h00 : ps1_r + 8'h01;
      if (!run2) ps2_r <= '0;
      else if (raw2) ps2_r <= tick2 ? 8'h00 : ps2_r + 8'h01;
      if (!run3) ps3_r <= '0;
      else if (raw3) ps3_r <= tick3 ? 8'h00 : ps3_r + 8'h01;
    end
  end

  // ****************************************
  // Counters and match
  // ****************************************
  logic m1, m2, m3, m32;
  assign m1 = (cnt1_r == per1_r);
  assign m2 = (cnt2_r == per2_r);
  assign m3 = (cnt3_r == per3_r);
  assign m32 = ({cnt3_r, cnt2_r} == {per3_r, per2_r});

  logic cnt_wr1, cnt_wr2, cnt_wr3;
  assign cnt_wr1 = wr && (avs_address_i == OFS_CNT1);
  assign cnt_wr2 = wr && (avs_address_i == OFS_CNT2);
  assign cnt_wr3 = wr && (avs_address_i == OFS_CNT3);

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt1_r <= '0;
    end else if (cnt_wr1) begin
      cnt1_r <= merge(cnt1_r, wd, lane_m, 16'hffff);
    end else if (tick1) begin
      cnt1_r <= m1 ? 16'h0000 : cnt1_r + 16'h0001;
    end
  end

  // Joined pair counts as one word, carry from low into high
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt2_r <= '0;
      cnt3_r <= '0;
    end else begin
      if (cnt_wr2) begin
        cnt2_r <= merge(cnt2_r, wd, lane_m, 16'hffff);
      end else if (tick2) begin
        if (joined) cnt2_r <= m32 ? 16'h0000 : cnt2_r + 16'h0001;
        else cnt2_r <= m2 ? 16'h0000 : cnt2_r + 16'h0001;
      end
      if (cnt_wr3) begin
        cnt3_r <= merge(cnt3_r, wd, lane_m, 16'hffff);
      end else if (joined && tick2) begin
        if (m32) cnt3_r <= 16'h0000;
        else if (cnt2_r == 16'hffff) cnt3_r <= cnt3_r + 16'h0001;
      end else if (tick3) begin
        cnt3_r <= m3 ? 16'h0000 : cnt3_r + 16'h0001;
      end
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [IRQ_W-1:0] ev, clr;
  assign ev[IRQ_PRIM] = (tick1 && m1) ||
                        (run1 && !c1.clock_source_sel && c1.gate_accumulate_en && p1_gate_fall);
  assign ev[IRQ_LOW] = tick2 && m2 && !joined;
  assign ev[IRQ_UP] = (tick3 && m3) || (joined && tick2 && m32);
  assign clr = (wr && avs_address_i == OFS_IRQ_STAT && avs_byteenable_i[0]) ?
               wd[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) stat_r <= '0;
    else stat_r <= (stat_r & ~clr) | ev; // Set wins over clear
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_o <= 1'b0;
      converter_trig_o <= 1'b0;
      lower_timebase_o <= '0;
      upper_timebase_o <= '0;
    end else begin
      irq_o <= |((stat_r & ~clr | ev) & mask_r);
      converter_trig_o <= joined && tick2 && m32;
      lower_timebase_o <= cnt2_r;
      upper_timebase_o <= cnt3_r;
    end
  end

  // ****************************************
  // Avalon slave: one wait cycle per access
  // ****************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (avs_address_i)
      OFS_CON1: rd_mux = con1_r;
      OFS_CNT1: rd_mux = cnt1_r;
      OFS_PER1: rd_mux = per1_r;
      OFS_CON2: rd_mux = con2_r;
      OFS_CNT2: rd_mux = cnt2_r;
      OFS_PER2: rd_mux = per2_r;
      OFS_CON3: rd_mux = con3_r;
      OFS_CNT3: rd_mux = cnt3_r;
      OFS_PER3: rd_mux = per3_r;
      OFS_IRQ_STAT: rd_mux = {13'h0000, stat_r};
      OFS_IRQ_MASK: rd_mux = {13'h0000, mask_r};
      OFS_MISC: rd_mux = {14'h0000, converter_trig_o, irq_o};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bus_st_r <= BUS_IDLE;
      rdata_r <= '0;
    end else begin
      case (bus_st_r)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_st_r <= BUS_RESP;
            rdata_r <= {16'h0000, rd_mux};
          end
        end
        BUS_RESP: bus_st_r <= BUS_IDLE;
        default: bus_st_r <= BUS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = !(bus_st_r == BUS_RESP);
  assign avs_readdata_o = rdata_r;
endmodule

/* tb/gts_timer_set_props.sv */
`timescale 1ns/1ps
module gts_timer_set_props (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [gts_pkg::ADDR_W-1:0] avs_address_i, // address
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic [31:0] avs_readdata_o, // read data
  input wire logic avs_waitrequest_o, // wait
  input wire logic irq_o, // interrupt
  input wire logic [15:0] lower_timebase_o, // lower count
  input wire logic [15:0] upper_timebase_o, // upper count
  input wire logic converter_trig_o // trigger
);
  import gts_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Bus, counter and trigger relations
  // ****************************************
  a_answer_next: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  a_idle_wait: assert property (
    !(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_rdata_hold: assert property (
    !(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o))
    else $error("read data moved without access");
  a_rdata_upper: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_lower_step: assert property (
    !avs_write_i |-> ##2 (lower_timebase_o == $past(lower_timebase_o) + 16'h0001
    || lower_timebase_o == 16'h0000 || $stable(lower_timebase_o)))
    else $error("lower count jumped");
  a_upper_step: assert property (
    !avs_write_i |-> ##2 (upper_timebase_o == $past(upper_timebase_o) + 16'h0001
    || upper_timebase_o == 16'h0000 || $stable(upper_timebase_o)))
    else $error("upper count jumped");
  a_trig_zero: assert property (
    converter_trig_o |-> ##[0:2] (lower_timebase_o == 16'h0000 && upper_timebase_o == 16'h0000))
    else $error("trigger without cleared pair");
  a_reset_quiet: assert property (
    $rose(rst_n_i) |-> !irq_o && !converter_trig_o && avs_waitrequest_o)
    else $error("outputs active at reset release");
  c_trig: cover property (converter_trig_o);
  c_irq: cover property ($rose(irq_o));
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind gts_timer_set gts_timer_set_props u_gts_timer_set_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .lower_timebase_o(lower_timebase_o),
  .upper_timebase_o(upper_timebase_o), .converter_trig_o(converter_trig_o));

/* tb/gts_pin_src.sv */
`timescale 1ns/1ps
module gts_pin_src (
  input wire logic clk_i, // bench clock
  input wire logic [2:0] run_i, // clock enables
  input wire logic [2:0] gate_i, // gate levels
  output gts_pkg::gts_pins_t pins_o // pin bundle
);
  import gts_pkg::*;
  logic [1:0] div_r = 2'b00;
  always_ff @(posedge clk_i) begin
    div_r <= div_r + 2'b01;
  end
  // Quarter rate keeps below the sampling limit; a stopped clock rests low
  assign pins_o.primary_ext_clock_pin = run_i[2] & div_r[1];
  assign pins_o.lower_ext_clock_pin = run_i[1] & div_r[1];
  assign pins_o.upper_ext_clock_pin = run_i[0] & div_r[1];
  assign pins_o.primary_gate = gate_i[2];
  assign pins_o.lower_gate = gate_i[1];
  assign pins_o.upper_gate = gate_i[0];
endmodule

/* tb/gts_timer_set_tb.sv */
`timescale 1ns/1ps
module gts_timer_set_tb;
  import gts_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic [5:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  gts_pins_t pins_i;
  logic cpu_idle_i;
  logic irq_o;
  logic [15:0] lower_timebase_o;
  logic [15:0] upper_timebase_o;
  logic converter_trig_o;
  logic [2:0] run;
  logic [2:0] gate;
  logic [15:0] rd;
  logic seen;
  logic [15:0] cmask [3] = '{CON1_MASK, CON2_MASK, CON3_MASK};
  int dv [4] = '{1, 8, 64, 256};
  int fails = 0;
  int comparisons = 0;
  int k;
  int j;
  gts_timer_set u_gts_timer_set (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i), .cpu_idle_i(cpu_idle_i),
    .irq_o(irq_o), .lower_timebase_o(lower_timebase_o), .upper_timebase_o(upper_timebase_o),
    .converter_trig_o(converter_trig_o));
  gts_pin_src u_gts_pin_src (.clk_i(clk_i), .run_i(run), .gate_i(gate), .pins_o(pins_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input int lo, input int hi, input logic [15:0] g);
    comparisons++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // Each access starts one edge after the last ended, so no signal is driven twice at one edge
  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask
  task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o[15:0];
    avs_read_i <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    bus_rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    test_done();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_n_i = 1'b0;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h3;
    cpu_idle_i = 1'b0;
    run = 3'b000;
    gate = 3'b000;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc(OFS_CON1, CON_RST);
    rdc(OFS_PER1, PER_RST);
    rdc(OFS_PER3, PER_RST);
    rdc(OFS_IRQ_STAT, 16'h0000);
    rdc(6'h30, 16'h0000);
    for (k = 0; k < 3; k++) begin
      bus_wr(6'(k * 12), 16'h7fff);
      rdc(6'(k * 12), cmask[k] & 16'h7fff);
      bus_wr(6'(k * 12), 16'h0000);
    end
    for (k = 0; k < 4; k++) begin
      bus_wr(OFS_CNT1, 16'h0000);
      bus_wr(OFS_CON1, 16'h8000 | 16'(k << 4));
      repeat (2048) @(posedge clk_i);
      bus_wr(OFS_CON1, 16'h0000);
      bus_rd(OFS_CNT1, rd);
      rng("prescaled count", 2048 / dv[k], 2056 / dv[k] + 1, rd);
      repeat (20) @(posedge clk_i);
      rdc(OFS_CNT1, rd);
    end
    bus_wr(OFS_PER1, 16'h0009);
    bus_wr(OFS_CNT1, 16'h0000);
    bus_wr(OFS_IRQ_MASK, 16'h0001);
    bus_wr(OFS_CON1, 16'h8000);
    for (k = 0; k < 12; k++) begin
      bus_rd(OFS_CNT1, rd);
      rng("count under period", 0, 9, rd);
    end
    chk("irq raised", 16'h0001, irq_o);
    bus_wr(OFS_CON1, 16'h0000);
    rdc(OFS_IRQ_STAT, 16'h0001);
    bus_wr(OFS_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 16'h0000, irq_o);
    bus_wr(OFS_IRQ_MASK, 16'h0001);
    bus_wr(OFS_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 16'h0000, irq_o);
    bus_wr(OFS_PER1, 16'hffff);
    bus_wr(OFS_CNT1, 16'h0000);
    bus_wr(OFS_CON1, 16'h8040);
    repeat (50) @(posedge clk_i);
    rdc(OFS_CNT1, 16'h0000);
    gate <= 3'b100;
    repeat (100) @(posedge clk_i);
    gate <= 3'b000;
    repeat (6) @(posedge clk_i);
    bus_wr(OFS_CON1, 16'h0000);
    bus_rd(OFS_CNT1, rd);
    rng("gated count", 95, 106, rd);
    rdc(OFS_IRQ_STAT, 16'h0001);
    bus_wr(OFS_IRQ_STAT, 16'h0007);
    // Gate bit set and gate low: an external clock must still count
    for (k = 0; k < 2; k++) begin
      bus_wr(OFS_CNT1, 16'h0000);
      bus_wr(OFS_CON1, 16'h8042 | 16'(k << 2));
      run <= 3'b100;
      repeat (400) @(posedge clk_i);
      run <= 3'b000;
      repeat (8) @(posedge clk_i);
      bus_wr(OFS_CON1, 16'h0000);
      bus_rd(OFS_CNT1, rd);
      rng("external count", 98, 101, rd);
    end
    cpu_idle_i <= 1'b1;
    for (k = 0; k < 2; k++) begin
      bus_wr(OFS_CNT1, 16'h0000);
      bus_wr(OFS_CON1, k == 0 ? 16'ha000 : 16'h8000);
      repeat (40) @(posedge clk_i);
      bus_rd(OFS_CNT1, rd);
      rng("idle count", k * 40, k * 50, rd);
    end
    cpu_idle_i <= 1'b0;
    bus_wr(OFS_CON1, 16'h0000);
    bus_wr(OFS_PER2, 16'h0002);
    bus_wr(OFS_PER3, 16'h0001);
    bus_wr(OFS_CNT2, 16'hfffc);
    bus_wr(OFS_CNT3, 16'h0000);
    bus_wr(OFS_IRQ_MASK, 16'h0004);
    bus_wr(OFS_CON3, 16'h0030);
    bus_wr(OFS_CON2, 16'h8008);
    seen = 1'b0;
    for (j = 0; j < 40 && converter_trig_o !== 1'b1; j++) begin
      @(posedge clk_i);
      seen = seen | (upper_timebase_o === 16'h0001);
    end
    rng("joined match delay", 4, 12, 16'(j));
    chk("carry into upper", 16'h0001, seen);
    bus_wr(OFS_CON2, 16'h0000);
    rdc(OFS_CNT3, 16'h0000);
    rdc(OFS_IRQ_STAT, 16'h0004);
    chk("joined irq", 16'h0001, irq_o);
    bus_wr(OFS_IRQ_STAT, 16'h0007);
    bus_wr(OFS_PER2, 16'h0003);
    // Upper period zero makes the 32-bit compare hit too, so a stray trigger would show
    bus_wr(OFS_PER3, 16'h0000);
    bus_wr(OFS_CNT2, 16'h0000);
    bus_wr(OFS_CON2, 16'h8000);
    seen = 1'b0;
    for (k = 0; k < 30; k++) begin
      @(posedge clk_i);
      seen = seen | converter_trig_o;
    end
    chk("separate trigger", 16'h0000, seen);
    bus_wr(OFS_CON2, 16'h0000);
    rdc(OFS_IRQ_STAT, 16'h0002);
    rdc(OFS_CNT3, 16'h0000);
    bus_rd(OFS_CNT2, rd);
    rng("lower count", 0, 3, rd);
    chk("lower time base", rd, lower_timebase_o);
    test_done();
  end
endmodule
